// >>> pkg/pdcp_consts.svh
// Offsets, field positions, reset values and timing counts of the port.
`ifndef PDCP_CONSTS_SVH
`define PDCP_CONSTS_SVH
`define PDCP_ADDR_W 8
`define PDCP_OFS_FUNC 8'h00
`define PDCP_OFS_POL 8'h04
`define PDCP_OFS_OUT 8'h08
`define PDCP_OFS_IN 8'h0C
`define PDCP_OFS_MODE 8'h10
`define PDCP_OFS_OVLIM 8'h14
`define PDCP_OFS_OVDLY 8'h18
`define PDCP_OFS_STAT 8'h1C
`define PDCP_OFS_CTRL 8'h20
`define PDCP_NPINS 7
`define PDCP_ALARM_PIN 0
`define PDCP_COMMON_PIN 1
`define PDCP_BLOCK_PIN 2
`define PDCP_CTRL_CLEAR 0
`define PDCP_CTRL_OUTEN 1
`define PDCP_RST_OVLIM 16'h7FFF
`define PDCP_RST_OVDLY 16'h000A
`define PDCP_DLY_MIN_US 16'h000A
`define PDCP_DLY_MAX_US 16'hFDE8
`define PDCP_CLK_MHZ 100
`define PDCP_BLOCK_LAT_NS 5000
`define PDCP_CLK_NS 10
`define PDCP_BLOCK_LAT_CYC (`PDCP_BLOCK_LAT_NS / `PDCP_CLK_NS)
`define PDCP_RESP_OKAY 2'b00
`define PDCP_RESP_SLVERR 2'b10
`endif

// >>> pkg/pdcp_pkg.sv
// Types shared by the digital control port and its users.
package pdcp_pkg;
  // Function assigned to one port pin.
  typedef enum logic [1:0] {
    FN_GENERAL,
    FN_SENSE,
    FN_ALARM,
    FN_BLOCK
  } pdcp_func_t;
  // Handling of the output-block input.
  typedef enum logic [1:0] {
    BLK_OFF,
    BLK_FOLLOW,
    BLK_LATCHED
  } pdcp_mode_t;
  // AXI4-Lite request from the master.
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pdcp_axil_req_t;
  // AXI4-Lite answer from the slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pdcp_axil_rsp_t;
  // Output and output-enable signals of each two-way port pin.
  typedef struct packed {
    logic [6:0] pin_out;
    logic [6:0] pin_oe_n;
  } pdcp_pins_t;
endpackage

// >>> src/pdcp_port.sv
// Seven-pin digital control port with overvoltage trip and output block.
`timescale 1ns/10ps
`include "pdcp_consts.svh"
module pdcp_port #(
  parameter int NPINS = `PDCP_NPINS,
  parameter logic [15:0] NEG_LIMIT = 16'h0CCC
) (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // Register bus.
  input wire pdcp_pkg::pdcp_axil_req_t axi_req,
  output pdcp_pkg::pdcp_axil_rsp_t axi_rsp,
  // Port pins.
  input wire logic [NPINS-1:0] pin_in,
  output pdcp_pkg::pdcp_pins_t pins,
  // Sensed output voltage, signed.
  input wire logic [15:0] sense_volt,
  // Persistent store of the block mode.
  input wire pdcp_pkg::pdcp_mode_t nv_mode,
  output logic nv_store,
  output pdcp_pkg::pdcp_mode_t nv_store_mode,
  // Output channel enable.
  output logic out_on
);
  import pdcp_pkg::*;

  // Cycles of one microsecond and of the block latency budget.
  localparam int US_CYC = `PDCP_CLK_MHZ;
  localparam int BLK_CYC = `PDCP_BLOCK_LAT_CYC;

  // Tells whether a function may be placed on a given pin.
  function automatic logic func_legal(input int idx, input pdcp_func_t f);
    func_legal = 1'b1;
    if (f == FN_ALARM && idx != `PDCP_ALARM_PIN) begin
      func_legal = 1'b0;
    end else if (f == FN_BLOCK && idx != `PDCP_BLOCK_PIN) begin
      func_legal = 1'b0;
    end
  endfunction

  // Configuration state.
  pdcp_func_t func_q [NPINS];
  logic [NPINS-1:0] pol_q; // One means negative polarity.
  logic [NPINS-1:0] out_word_q;
  pdcp_mode_t mode_q;
  logic [15:0] ov_lim_q;
  logic [15:0] ov_dly_q;
  logic outen_q;
  logic clear_q; // A clear is waiting for its cause to go.
  logic boot_q; // High in the first cycle after reset.

  // Protection state.
  logic ov_latch_q;
  logic ovn_latch_q;
  logic blk_latch_q;
  logic [6:0] pre_q;
  logic [15:0] us_cnt_q;
  logic blk_true_q;

  // Bus handshake state.
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Combinational views.
  logic wr_go;
  logic [NPINS-1:0] true_lvl;
  logic blk_true;
  logic blk_rise;
  logic ov_over;
  logic ovn_over;
  logic prot_any;
  logic blk_follow;
  logic alarm_on;
  logic [15:0] dly_eff;
  logic pin1_leave;

  // Every pin's true level under its polarity.
  assign true_lvl = pin_in ^ pol_q;
  assign blk_true = (func_q[`PDCP_BLOCK_PIN] == FN_BLOCK)
                    && true_lvl[`PDCP_BLOCK_PIN];
  // A true-going edge: rising when positive, falling when negative.
  assign blk_rise = blk_true && !blk_true_q;
  assign ov_over = $signed(sense_volt) >= $signed(ov_lim_q);
  assign ovn_over = $signed(sense_volt)
                    <= -$signed({1'b0, NEG_LIMIT});
  assign prot_any = ov_latch_q || ovn_latch_q || blk_latch_q;
  assign alarm_on = prot_any;
  assign blk_follow = (mode_q == BLK_FOLLOW) && blk_true;
  // Output follows the enable unless protection or a follow_block_mode block holds it.
  assign out_on = outen_q && !prot_any && !blk_follow;
  // The delay is held within its documented span.
  assign dly_eff = (ov_dly_q < `PDCP_DLY_MIN_US) ? `PDCP_DLY_MIN_US :
                   (ov_dly_q > `PDCP_DLY_MAX_US) ? `PDCP_DLY_MAX_US :
                   ov_dly_q;

  // Write takes place once both address and data are held.
  assign wr_go = ce && aw_held_q && w_held_q && !bvalid_q;
  assign pin1_leave = wr_go && (awaddr_q == `PDCP_OFS_FUNC)
    && (func_q[`PDCP_ALARM_PIN] == FN_ALARM)
    && (pdcp_func_t'(wdata_q[1:0]) != FN_ALARM);

  // Bus ready signals are combinational and forced low while the enable is low.
  assign axi_rsp.awready = ce && !aw_held_q && !bvalid_q;
  assign axi_rsp.wready = ce && !w_held_q && !bvalid_q;
  assign axi_rsp.arready = ce && !rvalid_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;

  // Address and data are caught in either order.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_held_q <= 1'b1;
        wdata_q <= axi_req.wdata;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write answer stands until the master takes it.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= `PDCP_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        // Unmapped and read-only offsets answer with an error.
        if (awaddr_q > `PDCP_OFS_CTRL || awaddr_q[1:0] != 2'b00
            || awaddr_q == `PDCP_OFS_IN || awaddr_q == `PDCP_OFS_STAT) begin
          bresp_q <= `PDCP_RESP_SLVERR;
        end else begin
          bresp_q <= `PDCP_RESP_OKAY;
        end
      end else if (axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data is captured on the same edge that takes the address.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PDCP_RESP_OKAY;
    end else if (ce) begin
      if (axi_req.arvalid && axi_rsp.arready) begin
        rvalid_q <= 1'b1;
        rresp_q <= `PDCP_RESP_OKAY;
        rdata_q <= 32'h0000_0000;
        if (axi_req.araddr == `PDCP_OFS_FUNC) begin
          for (int i = 0; i < NPINS; i++) begin
            rdata_q[2*i +: 2] <= func_q[i];
          end
          // Pin 2 reports the alarm while pin 1 carries it.
          if (func_q[`PDCP_ALARM_PIN] == FN_ALARM) begin
            rdata_q[3:2] <= FN_ALARM;
          end
        end else if (axi_req.araddr == `PDCP_OFS_POL) begin
          rdata_q[NPINS-1:0] <= pol_q;
        end else if (axi_req.araddr == `PDCP_OFS_OUT) begin
          rdata_q[NPINS-1:0] <= out_word_q;
        end else if (axi_req.araddr == `PDCP_OFS_IN) begin
          rdata_q[NPINS-1:0] <= pin_in;
        end else if (axi_req.araddr == `PDCP_OFS_MODE) begin
          rdata_q[1:0] <= mode_q;
        end else if (axi_req.araddr == `PDCP_OFS_OVLIM) begin
          rdata_q[15:0] <= ov_lim_q;
        end else if (axi_req.araddr == `PDCP_OFS_OVDLY) begin
          rdata_q[15:0] <= ov_dly_q;
        end else if (axi_req.araddr == `PDCP_OFS_STAT) begin
          rdata_q[5:0] <= {clear_q, out_on, blk_latch_q, ovn_latch_q,
                           ov_latch_q, alarm_on};
        end else if (axi_req.araddr == `PDCP_OFS_CTRL) begin
          rdata_q[`PDCP_CTRL_OUTEN] <= outen_q;
        end else begin
          rresp_q <= `PDCP_RESP_SLVERR;
        end
      end else if (axi_req.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Per-pin function registers, each written on its own field.
  for (genvar i = 0; i < NPINS; i++) begin : g_func
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        func_q[i] <= FN_SENSE;
      end else if (ce) begin
        if (i == `PDCP_COMMON_PIN && pin1_leave) begin
          func_q[i] <= FN_SENSE;
        end else if (wr_go && awaddr_q == `PDCP_OFS_FUNC
            && func_legal(i, pdcp_func_t'(wdata_q[2*i +: 2]))) begin
          // Pin 2 is not reprogrammed while pin 1 carries the alarm.
          if (!(i == `PDCP_COMMON_PIN
                && func_q[`PDCP_ALARM_PIN] == FN_ALARM)) begin
            func_q[i] <= pdcp_func_t'(wdata_q[2*i +: 2]);
          end
        end
      end
    end

    // Pin drivers; output enable is low while the pin is driven.
    always_comb begin
      pins.pin_out[i] = 1'b0;
      pins.pin_oe_n[i] = 1'b1;
      if (func_q[i] == FN_GENERAL) begin
        pins.pin_out[i] = out_word_q[i] ^ pol_q[i];
        pins.pin_oe_n[i] = 1'b0;
      end else if (func_q[i] == FN_ALARM) begin
        pins.pin_out[i] = alarm_on ^ pol_q[i];
        pins.pin_oe_n[i] = 1'b0;
      end
    end
  end

  // Plain settings written by software.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pol_q <= '0;
      out_word_q <= '0;
      ov_lim_q <= `PDCP_RST_OVLIM;
      ov_dly_q <= `PDCP_RST_OVDLY;
      outen_q <= 1'b0;
    end else if (ce && wr_go) begin
      if (awaddr_q == `PDCP_OFS_POL) begin
        pol_q <= wdata_q[NPINS-1:0];
      end else if (awaddr_q == `PDCP_OFS_OUT) begin
        out_word_q <= wdata_q[NPINS-1:0];
      end else if (awaddr_q == `PDCP_OFS_OVLIM) begin
        ov_lim_q <= wdata_q[15:0];
      end else if (awaddr_q == `PDCP_OFS_OVDLY) begin
        ov_dly_q <= wdata_q[15:0];
      end else if (awaddr_q == `PDCP_OFS_CTRL) begin
        outen_q <= wdata_q[`PDCP_CTRL_OUTEN];
      end
    end
  end

  // Block mode is reloaded from the store after reset, saved on each mode write other than 3.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      boot_q <= 1'b1;
      mode_q <= BLK_OFF;
      nv_store <= 1'b0;
      nv_store_mode <= BLK_OFF;
    end else if (ce) begin
      boot_q <= 1'b0;
      nv_store <= 1'b0;
      if (boot_q) begin
        mode_q <= nv_mode;
      end else if (wr_go && awaddr_q == `PDCP_OFS_MODE
                   && wdata_q[1:0] != 2'b11) begin
        mode_q <= pdcp_mode_t'(wdata_q[1:0]);
        nv_store <= 1'b1;
        nv_store_mode <= pdcp_mode_t'(wdata_q[1:0]);
      end
    end
  end

  // Overvoltage delay: microsecond counter while the limit is reached or exceeded.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pre_q <= '0;
      us_cnt_q <= '0;
    end else if (ce) begin
      if (!ov_over) begin
        pre_q <= '0;
        us_cnt_q <= '0;
      end else if (pre_q == 7'(US_CYC - 1)) begin
        pre_q <= '0;
        if (us_cnt_q != 16'hFFFF) begin
          us_cnt_q <= us_cnt_q + 16'h0001;
        end
      end else begin
        pre_q <= pre_q + 7'h01;
      end
    end
  end

  // Protection clear waits for every cause to go; a new trip wins.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clear_q <= 1'b0;
      ov_latch_q <= 1'b0;
      ovn_latch_q <= 1'b0;
      blk_latch_q <= 1'b0;
      blk_true_q <= 1'b0;
    end else if (ce) begin
      blk_true_q <= blk_true;
      if (wr_go && awaddr_q == `PDCP_OFS_CTRL
          && wdata_q[`PDCP_CTRL_CLEAR]) begin
        clear_q <= 1'b1;
      end else if (clear_q && !ov_over && !ovn_over && !blk_true) begin
        clear_q <= 1'b0;
      end
      if (ov_over && us_cnt_q >= dly_eff) begin
        ov_latch_q <= 1'b1;
      end else if (clear_q && !ov_over && !ovn_over && !blk_true) begin
        ov_latch_q <= 1'b0;
      end
      if (ovn_over) begin
        ovn_latch_q <= 1'b1;
      end else if (clear_q && !ov_over && !blk_true) begin
        ovn_latch_q <= 1'b0;
      end
      if (mode_q == BLK_LATCHED && blk_rise) begin
        blk_latch_q <= 1'b1;
      end else if (clear_q && !ov_over && !ovn_over && !blk_true) begin
        blk_latch_q <= 1'b0;
      end
    end
  end

  // Checks on the behaviour above.
  a_sense_no_drive: assert property (@(posedge sys_clk) disable iff (reset)
    func_q[4] == FN_SENSE |-> pins.pin_oe_n[4])
    else $error("sense-only pin is driven");
  a_alarm_pin_sense: assert property (@(posedge sys_clk) disable iff (reset)
    func_q[0] == FN_ALARM |-> pins.pin_out[0] == (prot_any ^ pol_q[0]))
    else $error("alarm pin does not show protection");
  a_pin2_locked: assert property (@(posedge sys_clk) disable iff (reset)
    func_q[0] == FN_ALARM && !pin1_leave |=> $stable(func_q[1]))
    else $error("pin 2 changed while pin 1 carries the alarm");
  a_pin2_released: assert property (@(posedge sys_clk) disable iff (reset)
    pin1_leave |=> func_q[1] == FN_SENSE && func_q[0] != FN_ALARM)
    else $error("pin 2 not sense-only after pin 1 left alarm");
  a_block_latency: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == BLK_FOLLOW && ce && blk_true |-> ##[0:BLK_CYC] !out_on)
    else $error("output not blocked in time");
  a_block_off: assert property (@(posedge sys_clk) disable iff (reset)
    mode_q == BLK_OFF && outen_q && !prot_any |-> out_on)
    else $error("block input not ignored in off mode");
  a_ov_no_early: assert property (@(posedge sys_clk) disable iff (reset)
    ce && !ov_over ##1 ce && ov_over [*8] |-> !$rose(ov_latch_q))
    else $error("overvoltage tripped before its delay");
  a_alarm_holds: assert property (@(posedge sys_clk) disable iff (reset)
    alarm_on && !clear_q |=> alarm_on)
    else $error("alarm released without a clear");
  a_latch_block: assert property (@(posedge sys_clk) disable iff (reset)
    ce && mode_q == BLK_LATCHED && blk_rise |=> !out_on [*2])
    else $error("latched block did not hold the output off");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (reset)
    axi_req.arvalid && axi_rsp.arready |=> rvalid_q)
    else $error("read not answered next cycle");
  c_ov_trip: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(ov_latch_q));
  c_follow_block: cover property (@(posedge sys_clk) disable iff (reset)
    blk_follow ##[1:20] !blk_follow && out_on);
  c_pin1_leave: cover property (@(posedge sys_clk) disable iff (reset)
    pin1_leave);
  c_clear_wait: cover property (@(posedge sys_clk) disable iff (reset)
    clear_q && prot_any ##[1:50] !prot_any);
endmodule

// >>> verif/pdcp_relay_model.sv
// Far-side relay and logic circuits that share the port pins.
`timescale 1ns/10ps
module pdcp_relay_model (
  // Pins as the port drives them.
  input wire pdcp_pkg::pdcp_pins_t pins,
  // Levels that the external circuits put on lines the port releases.
  input wire logic [6:0] ext_lvl,
  // Resolved line levels seen by the port.
  output logic [6:0] pin_in,
  // High while the isolated alarm output conducts.
  output logic alarm_on
);
  import pdcp_pkg::*;
  // A driven line follows the port, a released one the external circuit.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pin_in[i] = pins.pin_oe_n[i] ? ext_lvl[i] : pins.pin_out[i];
    end
  end
  // The optocoupler on pin 1 conducts while the port drives that line high.
  assign alarm_on = !pins.pin_oe_n[0] && pins.pin_out[0];
endmodule

// >>> verif/pdcp_port_tb.sv
// Self-checking bench for the digital control port.
`timescale 1ns/10ps
`include "pdcp_consts.svh"
module pdcp_port_tb;
  import pdcp_pkg::*;
  // Short names for the register offsets.
  localparam logic [7:0] FN = `PDCP_OFS_FUNC;
  localparam logic [7:0] POL = `PDCP_OFS_POL;
  localparam logic [7:0] CTRL = `PDCP_OFS_CTRL;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  pdcp_axil_req_t req = '0;
  pdcp_axil_rsp_t rsp;
  pdcp_pins_t pins;
  logic [6:0] pin_in;
  logic [6:0] ext_lvl = 7'h7f;
  logic [15:0] sense_volt = 16'h0000;
  pdcp_mode_t nv_store_mode;
  logic nv_store;
  int n_store = 0; // Save pulses seen on the persistent store.
  logic out_on;
  logic alarm_on;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] rdat;
  logic [1:0] resp;

  // The clock toggles every half period of 5 ns.
  always #5 sys_clk = ~sys_clk;

  // Device under test, always clocked.
  pdcp_port i_pdcp_port (
    .sys_clk(sys_clk), .reset(reset), .ce(1'b1), .axi_req(req),
    .axi_rsp(rsp), .pin_in(pin_in), .pins(pins), .sense_volt(sense_volt),
    .nv_mode(BLK_OFF), .nv_store(nv_store), .nv_store_mode(nv_store_mode),
    .out_on(out_on));

  // External circuits on the pins.
  pdcp_relay_model i_pdcp_relay_model (
    .pins(pins), .ext_lvl(ext_lvl), .pin_in(pin_in), .alarm_on(alarm_on));

  // Every block mode write other than 3 must give exactly one save pulse.
  always @(posedge sys_clk) begin
    if (nv_store === 1'b1) begin
      n_store++;
    end
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write; address and data are offered together and each is held.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(posedge sys_clk);
      if (ta && tw && rsp.bvalid === 1'b1) begin
        tb = 1'b1;
        resp = rsp.bresp;
        req.bready <= 1'b0;
      end
      if (!ta && rsp.awready === 1'b1) begin
        ta = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!tw && rsp.wready === 1'b1) begin
        tw = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    if (!tb) begin
      chk(32'h0000_0000, 32'h0000_0001);
    end
  endtask

  // Bus read; the address is held until taken, rready until the answer.
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    ta = 1'b0;
    tr = 1'b0;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(posedge sys_clk);
      if (ta && rsp.rvalid === 1'b1) begin
        tr = 1'b1;
        rdat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
      end
      if (!ta && rsp.arready === 1'b1) begin
        ta = 1'b1;
        req.arvalid <= 1'b0;
      end
    end
    if (!tr) begin
      chk(32'h0000_0000, 32'h0000_0001);
    end
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask

  // Waits a number of clock cycles.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end

  // Main test sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(FN, 32'h0000_1555);
    chk(32'(pins.pin_oe_n), 32'h0000_007f);
    $display("test reset done");
    wr(FN, 32'h0000_0000);
    wr(`PDCP_OFS_OUT, 32'h0000_0055);
    chk(32'(pins.pin_out), 32'h0000_0055);
    chk(32'(pins.pin_oe_n), 32'h0000_0000);
    wr(POL, 32'h0000_0001);
    chk(32'(pins.pin_out), 32'h0000_0054);
    wr(POL, 32'h0000_0000);
    $display("test general done");
    // Pin 5 sensed low although its output bit is one.
    wr(FN, 32'h0000_0100);
    ext_lvl[4] <= 1'b0;
    cyc(3);
    chk(32'(pins.pin_oe_n), 32'h0000_0010);
    rchk(`PDCP_OFS_IN, 32'h0000_0045);
    $display("test sense done");
    // Pin 2 follows pin 1 and the alarm is refused on pin 3.
    wr(FN, 32'h0000_0002);
    rchk(FN, 32'h0000_000a);
    wr(FN, 32'h0000_0026);
    rchk(FN, 32'h0000_000a);
    chk(32'(alarm_on), 32'h0000_0000);
    wr(POL, 32'h0000_0001);
    chk(32'(alarm_on), 32'h0000_0001);
    wr(POL, 32'h0000_0000);
    wr(FN, 32'h0000_0000);
    rchk(FN, 32'h0000_0004);
    $display("test alarm done");
    // Overvoltage: a short excursion is filtered, a long one trips.
    wr(FN, 32'h0000_0002);
    wr(CTRL, 32'h0000_0002);
    wr(`PDCP_OFS_OVLIM, 32'h0000_1000);
    wr(`PDCP_OFS_OVDLY, 32'h0000_000a);
    chk(32'(out_on), 32'h0000_0001);
    sense_volt <= 16'h1000;
    cyc(500);
    chk(32'(out_on), 32'h0000_0001);
    sense_volt <= 16'h0000;
    cyc(5);
    sense_volt <= 16'h1000;
    cyc(1100);
    chk(32'(out_on), 32'h0000_0000);
    chk(32'(alarm_on), 32'h0000_0001);
    wr(CTRL, 32'h0000_0003);
    cyc(3);
    chk(32'(alarm_on), 32'h0000_0001);
    sense_volt <= 16'h0000;
    cyc(5);
    chk(32'(alarm_on), 32'h0000_0000);
    chk(32'(out_on), 32'h0000_0001);
    // A brief reversed-lead reading trips and stays latched.
    sense_volt <= 16'hf334;
    cyc(3);
    sense_volt <= 16'h0000;
    cyc(20);
    chk(32'(out_on), 32'h0000_0000);
    chk(32'(alarm_on), 32'h0000_0001);
    wr(CTRL, 32'h0000_0003);
    cyc(3);
    chk(32'(out_on), 32'h0000_0001);
    $display("test overvoltage done");
    // Output block on pin 3 in follow, off and latched modes.
    wr(FN, 32'h0000_0030);
    ext_lvl[2] <= 1'b0;
    wr(`PDCP_OFS_MODE, 32'h0000_0001);
    chk(32'(nv_store_mode), 32'(BLK_FOLLOW));
    ext_lvl[2] <= 1'b1;
    cyc(3);
    chk(32'(out_on), 32'h0000_0000);
    ext_lvl[2] <= 1'b0;
    cyc(3);
    chk(32'(out_on), 32'h0000_0001);
    wr(POL, 32'h0000_0004);
    cyc(3);
    chk(32'(out_on), 32'h0000_0000);
    wr(POL, 32'h0000_0000);
    wr(`PDCP_OFS_MODE, 32'h0000_0000);
    ext_lvl[2] <= 1'b1;
    cyc(3);
    chk(32'(out_on), 32'h0000_0001);
    ext_lvl[2] <= 1'b0;
    wr(`PDCP_OFS_MODE, 32'h0000_0002);
    chk(32'(nv_store_mode), 32'(BLK_LATCHED));
    ext_lvl[2] <= 1'b1;
    cyc(3);
    ext_lvl[2] <= 1'b0;
    cyc(3);
    chk(32'(out_on), 32'h0000_0000);
    wr(CTRL, 32'h0000_0003);
    cyc(3);
    chk(32'(out_on), 32'h0000_0001);
    // With negative polarity the falling edge latches the block.
    wr(`PDCP_OFS_MODE, 32'h0000_0000);
    ext_lvl[2] <= 1'b1;
    wr(POL, 32'h0000_0004);
    wr(`PDCP_OFS_MODE, 32'h0000_0002);
    cyc(3);
    chk(32'(out_on), 32'h0000_0001);
    ext_lvl[2] <= 1'b0;
    cyc(3);
    chk(32'(out_on), 32'h0000_0000);
    chk(32'(n_store), 32'h0000_0005);
    $display("test block done");
    // Unmapped and read-only places answer with an error.
    rd(8'h40);
    chk(32'(resp), 32'(`PDCP_RESP_SLVERR));
    wr(`PDCP_OFS_IN, 32'h0000_0000);
    chk(32'(resp), 32'(`PDCP_RESP_SLVERR));
    $display("test bus done");
    close_out();
  end
endmodule
